// >>> verilog/itm_top.sv
// i2c slave front end with bus-stall timeout and oscillator monitor
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// - scl held low past 25 ms is detected and flagged as an event.
// - scl low for 35 ms resets the serial interface; next start accepted.
// - on the stall reset the slave releases sda.
// - stall timer only advances on time-base ticks, so no osc means no reset.
// - oscillator stopped about 100 ms sets the oscillator stopped flag.
// - slave answers only if strap level equals its address bit.
// - output function select picks square wave or alarm interrupt output.
// - serial interface serves standard and fast mode up to 400 kHz.
// - time base is internal oscillator or external 32.768 kHz input.
// - pointer after address, auto increments, wraps 10h to 00h until stop.
// - alarm flag with irq enable and select set holds output low until cleared.
// - oscillator disable bit 0 runs the oscillator, 1 stops it.
module itm_top
   import itm_pkg::*;
#(
   parameter int STALL_MIN = STALL_MIN_TICKS,
   parameter int STALL_MAX = STALL_MAX_TICKS,
   parameter int OSF_LIMIT = OSF_CYCLES,
   parameter int TB_DIV = INT_DIV,
   parameter logic [6:0] SLAVE_BASE = SLAVE_ADDR_BASE
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic address_select_pin_i,
   input wire logic oscillator_input_i,
   input wire logic alarm_event_i,
   output logic square_wave_or_irq_out_o,
   output logic square_wave_or_irq_out_oe_n_o
);
   // refuse values the counters cannot hold
   generate
      if (STALL_MIN < 1 || STALL_MIN >= STALL_MAX || STALL_MAX > 4095) begin : g_e1
         $error("stall limits out of range");
      end
      if (OSF_LIMIT < 2 || OSF_LIMIT >= (1 << 23)) begin : g_e2
         $error("oscillator stop limit out of range");
      end
      if (TB_DIV < 2 || TB_DIV > 4095 || CLK_HZ < 40 * SCL_MAX_KHZ * 1000) begin : g_e3
         $error("clock ratio out of range");
      end
   endgenerate

   logic scl_s, sda_s, osc_s, strap_s;
   logic scl_q, sda_q, osc_q;
   logic [7:0] ctrl;
   logic clk_ext, af, oscillator_stopped_flag;
   logic [11:0] div_cnt, stall_cnt;
   logic [22:0] osf_cnt;
   logic [14:0] pres;
   itm_state_type state;
   itm_kind_type kind;
   logic [3:0] bitcnt;
   logic [7:0] shreg, txbyte;
   logic [4:0] ptr;
   logic rw, sda_oe_n, sqw_oe_n, av_wait, irq;
   logic [31:0] av_rdata;
   logic [N_EV-1:0] irq_stat, irq_en;
   logic [7:0] mem [0:16];

   itm_sync #(
      .W(4),
      .RST_VAL(4'h3)
   ) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i({address_select_pin_i, oscillator_input_i, sda_i, scl_i}),
      .q_o({strap_s, osc_s, sda_s, scl_s})
   );

   // bus edges and conditions
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_det = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_det = scl_s & scl_q & ~sda_q & sda_s;

   // time base
   wire osc_run = ~ctrl[CTRL_OSC_DIS];
   wire int_tick = div_cnt == 12'(TB_DIV - 1);
   wire ext_tick = osc_s & ~osc_q;
   wire tb_tick = osc_run & (clk_ext ? ext_tick : int_tick);

   // stall timer
   wire stall_hit_min = tb_tick & ~scl_s & (stall_cnt == 12'(STALL_MIN - 1));
   wire stall_hit_max = tb_tick & ~scl_s & (stall_cnt == 12'(STALL_MAX - 1));
   wire bus_reset = stall_cnt >= 12'(STALL_MAX);
   wire osf_hit = ~tb_tick & (osf_cnt == 23'(OSF_LIMIT - 1));

   // i2c decode
   wire addr_match = (shreg[7:2] == SLAVE_BASE[6:1]) & (shreg[1] == strap_s);
   wire byte_end = (state == ST_RX) & scl_fall & (bitcnt == 4'h8);
   wire i2c_wr = byte_end & (kind == K_DATA);
   wire [4:0] ptr_inc = (ptr == REG_LAST) ? 5'h00 : ptr + 5'h01;
   wire [4:0] ptr_load = (shreg > {3'h0, REG_LAST}) ? 5'h00 : shreg[4:0];
   wire [7:0] stat_byte = {oscillator_stopped_flag, 6'h00, af};
   wire [7:0] rd_byte = (ptr == REG_CTRL) ? ctrl :
                        (ptr == REG_STAT) ? stat_byte : mem[ptr];

   // avalon decode
   wire av_req = avs_read_i | avs_write_i;
   wire av_wr = avs_write_i & ~av_wait;
   wire sel_ctrl = avs_address_i == AV_CTRL;
   wire sel_stat = avs_address_i == AV_STAT;
   wire sel_src = avs_address_i == AV_CLKSRC;
   wire sel_ist = avs_address_i == AV_IRQ_STAT;
   wire sel_iclr = avs_address_i == AV_IRQ_CLR;
   wire sel_ien = avs_address_i == AV_IRQ_EN;
   wire [7:0] wd8 = avs_writedata_i[7:0];
   wire busy = state != ST_IDLE;
   wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl} :
                        sel_stat ? {28'h0000000, busy, bus_reset, oscillator_stopped_flag, af} :
                        sel_src ? {31'h00000000, clk_ext} :
                        sel_ist ? {28'h0000000, irq_stat} :
                        sel_ien ? {28'h0000000, irq_en} : 32'h00000000;

   // control writes and flag clears
   wire i2c_ctrl_wr = i2c_wr & (ptr == REG_CTRL);
   wire i2c_stat_wr = i2c_wr & (ptr == REG_STAT);
   wire av_stat_wr = av_wr & sel_stat;
   wire clr_af = (i2c_stat_wr & ~shreg[STAT_AF]) | (av_stat_wr & ~wd8[STAT_AF]);
   wire clr_osf = (i2c_stat_wr & ~shreg[STAT_OSF])
                | (av_stat_wr & ~wd8[STAT_OSF]);
   wire [N_EV-1:0] ev = {alarm_event_i, osf_hit, stall_hit_max, stall_hit_min};
   wire [N_EV-1:0] ev_clr = (av_wr & sel_iclr) ? avs_writedata_i[N_EV-1:0] : '0;

   // square wave select
   wire [1:0] rs = ctrl[CTRL_RS_LO +: 2];
   wire sq_lvl = (rs == 2'h0) ? pres[14] :
                 (rs == 2'h1) ? pres[2] :
                 (rs == 2'h2) ? pres[1] : pres[0];
   // irq held low while flag set
   wire next_sqw_oe_n = ctrl[CTRL_OFS] ? ~(af & ctrl[CTRL_AIE]) : sq_lvl;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         osc_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         osc_q <= osc_s;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt <= 12'h000;
         pres <= 15'h0000;
      end else begin
         div_cnt <= int_tick ? 12'h000 : div_cnt + 12'h001;
         pres <= pres + {14'h0000, tb_tick};
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stall_cnt <= 12'h000;
      end else if (scl_s) begin
         stall_cnt <= 12'h000;
      end else if (tb_tick && !bus_reset) begin
         stall_cnt <= stall_cnt + 12'h001;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osf_cnt <= 23'h000000;
         oscillator_stopped_flag <= OSF_RESET;
         af <= 1'b0;
      end else begin
         if (tb_tick) begin
            osf_cnt <= 23'h000000;
         end else if (osf_cnt != 23'(OSF_LIMIT)) begin
            osf_cnt <= osf_cnt + 23'h000001;
         end
         oscillator_stopped_flag <= osf_hit | (oscillator_stopped_flag & ~clr_osf);
         af <= alarm_event_i | (af & ~clr_af);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= CTRL_RESET;
         clk_ext <= 1'b0;
         irq_en <= '0;
      end else if (i2c_ctrl_wr) begin
         ctrl <= shreg & CTRL_MASK;
      end else if (av_wr) begin
         if (sel_ctrl) begin
            ctrl <= wd8 & CTRL_MASK;
         end
         if (sel_src) begin
            clk_ext <= avs_writedata_i[0];
         end
         if (sel_ien) begin
            irq_en <= avs_writedata_i[N_EV-1:0];
         end
      end
   end

   // register bytes other than control and status
   always_ff @(posedge mclk_i) begin
      if (i2c_wr && ptr != REG_CTRL && ptr != REG_STAT) begin
         mem[ptr] <= shreg;
      end
   end

   // i2c slave
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         kind <= K_ADDR;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         txbyte <= 8'h00;
         ptr <= 5'h00;
         rw <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (bus_reset || stop_det) begin
         state <= ST_IDLE;
         sda_oe_n <= 1'b1;
      end else if (start_det) begin
         state <= ST_RX;
         kind <= K_ADDR;
         bitcnt <= 4'h0;
         sda_oe_n <= 1'b1;
      end else begin
         unique case (state)
            ST_IDLE: begin
               sda_oe_n <= 1'b1;
            end
            ST_RX: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_end) begin
                  if (kind == K_ADDR && !addr_match) begin
                     state <= ST_IDLE;
                  end else begin
                     state <= ST_ACK;
                     sda_oe_n <= 1'b0;
                     if (kind == K_ADDR) begin
                        rw <= shreg[0];
                     end else if (kind == K_PTR) begin
                        ptr <= ptr_load;
                     end else begin
                        ptr <= ptr_inc;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (rw) begin
                     state <= ST_TX;
                     sda_oe_n <= rd_byte[7];
                     txbyte <= {rd_byte[6:0], 1'b0};
                     bitcnt <= 4'h1;
                     ptr <= ptr_inc;
                  end else begin
                     state <= ST_RX;
                     sda_oe_n <= 1'b1;
                     bitcnt <= 4'h0;
                     kind <= (kind == K_ADDR) ? K_PTR : K_DATA;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt == 4'h8) begin
                     state <= ST_RACK;
                     sda_oe_n <= 1'b1;
                  end else begin
                     sda_oe_n <= txbyte[7];
                     txbyte <= {txbyte[6:0], 1'b0};
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     state <= ST_IDLE;
                  end else begin
                     bitcnt <= 4'h0;
                  end
               end else if (scl_fall && bitcnt == 4'h0) begin
                  state <= ST_TX;
                  sda_oe_n <= rd_byte[7];
                  txbyte <= {rd_byte[6:0], 1'b0};
                  bitcnt <= 4'h1;
                  ptr <= ptr_inc;
               end
            end
            default: begin
               state <= ST_IDLE;
               sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // avalon slave, irq and pin outputs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         av_wait <= 1'b1;
         av_rdata <= 32'h00000000;
         irq_stat <= '0;
         irq <= 1'b0;
         sqw_oe_n <= 1'b1;
      end else begin
         av_wait <= ~(av_req & av_wait);
         if (avs_read_i && av_wait) begin
            av_rdata <= rd_mux;
         end
         irq_stat <= ev | (irq_stat & ~ev_clr);
         irq <= |(irq_stat & irq_en);
         sqw_oe_n <= next_sqw_oe_n;
      end
   end

   assign avs_waitrequest_o = av_wait;
   assign avs_readdata_o = av_rdata;
   assign irq_o = irq;
   assign sda_oe_n_o = sda_oe_n;
   assign square_wave_or_irq_out_oe_n_o = sqw_oe_n;

   // open-drain pins only ever drive low
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_o <= 1'b0;
         square_wave_or_irq_out_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         square_wave_or_irq_out_o <= 1'b0;
      end
   end

   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_addr_end;
      byte_end && kind == K_ADDR;
   endsequence
   sequence s_stall_min;
      tb_tick && !scl_s && stall_cnt == 12'(STALL_MIN - 1);
   endsequence

   a_strap_mismatch: assert property (
      s_addr_end ##0 (shreg[1] != strap_s) |=> state == ST_IDLE
   ) else $error("slave answered with strap mismatch");
   a_stall_seen: assert property (
      s_stall_min |=> irq_stat[EV_STALL_SEEN] && stall_cnt == 12'(STALL_MIN)
   ) else $error("stall detection missed");
   a_stall_reset: assert property (
      bus_reset |=> state == ST_IDLE
   ) else $error("interface not reset on stall");
   a_stall_release: assert property (
      bus_reset |=> sda_oe_n_o ##1 sda_oe_n_o || !bus_reset
   ) else $error("sda not released on stall");
   a_stall_clear: assert property (
      scl_s |=> stall_cnt == 12'h000
   ) else $error("stall timer not cleared");
   a_osc_gate: assert property (
      (!tb_tick && !scl_s) |=> $stable(stall_cnt)
   ) else $error("stall timer moved without tick");
   a_osf_delay: assert property (
      (osf_cnt == 23'(OSF_LIMIT - 1) && !tb_tick) |=> oscillator_stopped_flag
   ) else $error("oscillator stop flag not set");
   a_osf_watch: assert property (
      tb_tick |=> osf_cnt == 23'h000000
   ) else $error("watchdog not restarted by tick");
   a_osc_disable: assert property (
      ctrl[CTRL_OSC_DIS] |-> !tb_tick
   ) else $error("tick while oscillator disabled");
   a_irq_hold: assert property (
      (ctrl[CTRL_OFS] && ctrl[CTRL_AIE] && af) |=> !sqw_oe_n
   ) else $error("interrupt output not driven low");
   a_sqw_mode: assert property (
      !ctrl[CTRL_OFS] |=> sqw_oe_n == $past(sq_lvl)
   ) else $error("square wave not on output");
   a_ptr_wrap: assert property (
      ptr <= REG_LAST
   ) else $error("pointer beyond last register");
   a_bus_answer: assert property (
      (av_req && av_wait) |=> !av_wait ##1 av_wait
   ) else $error("waitrequest did not drop for one cycle");
endmodule : itm_top

// >>> verilog/itm_pkg.sv
// shared constants and types of the i2c timeout and oscillator monitor
package itm_pkg;
   // clock rates
   localparam int CLK_HZ = 40_000_000;
   localparam int TB_HZ = 32_768;
   localparam int SCL_MAX_KHZ = 400;
   // times in ms as specified
   localparam int STALL_MIN_MS = 25;
   localparam int STALL_MAX_MS = 35;
   localparam int OSF_MS = 100;
   // least stall time rounds up, longest rounds down, both in time-base ticks
   localparam int STALL_MIN_TICKS = (STALL_MIN_MS * TB_HZ + 999) / 1000;
   localparam int STALL_MAX_TICKS = (STALL_MAX_MS * TB_HZ) / 1000;
   // oscillator stop interval in mclk cycles
   localparam int OSF_CYCLES = OSF_MS * (CLK_HZ / 1000);
   // internal time-base divider from mclk
   localparam int INT_DIV = CLK_HZ / TB_HZ;
   // i2c register map
   localparam logic [4:0] REG_CTRL = 5'h07;
   localparam logic [4:0] REG_STAT = 5'h08;
   localparam logic [4:0] REG_LAST = 5'h10;
   localparam int CTRL_OSC_DIS = 7;
   localparam int CTRL_ACE = 6;
   localparam int CTRL_OFS = 3;
   localparam int CTRL_RS_LO = 1;
   localparam int CTRL_AIE = 0;
   localparam logic [7:0] CTRL_RESET = 8'h0e;
   localparam logic [7:0] CTRL_MASK = 8'hcf;
   localparam int STAT_OSF = 7;
   localparam int STAT_AF = 0;
   localparam logic OSF_RESET = 1'b1;
   // slave address, bit 0 comes from the strap; value is arbitrary
   localparam logic [6:0] SLAVE_ADDR_BASE = 7'h50;
   // avalon byte offsets
   localparam logic [4:0] AV_CTRL = 5'h00;
   localparam logic [4:0] AV_STAT = 5'h04;
   localparam logic [4:0] AV_CLKSRC = 5'h08;
   localparam logic [4:0] AV_IRQ_STAT = 5'h0c;
   localparam logic [4:0] AV_IRQ_CLR = 5'h10;
   localparam logic [4:0] AV_IRQ_EN = 5'h14;
   // event bits of the interrupt registers
   localparam int EV_STALL_SEEN = 0;
   localparam int EV_STALL_RST = 1;
   localparam int EV_OSC_STOP = 2;
   localparam int EV_ALARM = 3;
   localparam int N_EV = 4;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACK = 3'b011,
      ST_TX = 3'b010,
      ST_RACK = 3'b110
   } itm_state_type;
   typedef enum logic [1:0] {
      K_ADDR = 2'b00,
      K_PTR = 2'b01,
      K_DATA = 2'b11
   } itm_kind_type;
endpackage : itm_pkg

// >>> verilog/itm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module itm_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta[i] <= RST_VAL[i];
               q_o[i] <= RST_VAL[i];
            end else begin
               meta[i] <= d_i[i];
               q_o[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule : itm_sync

// >>> tb/itm_i2c_master.sv
// i2c bus master model driving scl and sda
`timescale 1ns/1ps
module itm_i2c_master (
   input wire logic mclk_i,
   input wire logic sda_line_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // quarter bit, 400 khz at most, low phase short
   task automatic q;
      repeat (25) @(posedge mclk_i);
   endtask : q
   task automatic start;
      sda_o <= 1'b0;
      q();
      scl_o <= 1'b0;
      q();
   endtask : start
   task automatic put_bit(input logic b, output logic seen);
      sda_o <= b;
      q();
      scl_o <= 1'b1;
      q();
      @(negedge mclk_i);
      seen = sda_line_i;
      q();
      scl_o <= 1'b0;
      q();
   endtask : put_bit
   task automatic send8(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(b[i], s);
   endtask : send8
   task automatic xfer(input logic [7:0] b, output logic ack);
      logic s;
      send8(b);
      put_bit(1'b1, s);
      ack = ~s;
   endtask : xfer
   task automatic stop;
      sda_o <= 1'b0;
      q();
      scl_o <= 1'b1;
      q();
      sda_o <= 1'b1;
      q();
   endtask : stop
   task automatic idle;
      sda_o <= 1'b1;
      q();
      scl_o <= 1'b1;
      q();
   endtask : idle
   task automatic hold_low(input int n);
      scl_o <= 1'b0;
      repeat (n) @(posedge mclk_i);
      idle();
   endtask : hold_low
endmodule : itm_i2c_master

// >>> tb/test_i2c_slave_timeout_osc_monitor.sv
// self-checking bench of the i2c timeout and oscillator monitor
`timescale 1ns/1ps
module test_i2c_slave_timeout_osc_monitor;
   import itm_pkg::*;
   logic mclk_i, rst_n_i, avs_read_i, avs_write_i, irq_o;
   logic [4:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic avs_waitrequest_o, sda_o, sda_oe_n_o, address_select_pin_i;
   logic oscillator_input_i, alarm_event_i, osc_run, m_sda;
   logic square_wave_or_irq_out_o, square_wave_or_irq_out_oe_n_o;
   wire scl_i;
   wire sda_i;
   int mismatches = 0;
   int checked = 0;
   // open-drain data line with pull-up
   assign sda_i = m_sda & (sda_oe_n_o | sda_o);
   itm_top #(.OSF_LIMIT(200), .TB_DIV(8))
   dut (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o,
      .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .address_select_pin_i,
      .oscillator_input_i, .alarm_event_i, .square_wave_or_irq_out_o,
      .square_wave_or_irq_out_oe_n_o);
   itm_i2c_master m (.mclk_i, .sda_line_i(sda_i), .scl_o(scl_i),
      .sda_o(m_sda));
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   initial begin
      oscillator_input_i = 1'b0;
      #37;
      forever begin
         #100;
         if (osc_run) oscillator_input_i = ~oscillator_input_i;
      end
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask : wait_n
   task automatic av(input logic wr, input logic [4:0] a,
         input logic [31:0] d, output logic [31:0] rd);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : av
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] x;
      av(1'b1, a, d, x);
   endtask : wr
   task automatic rdc(input string nm, input logic [4:0] a,
         input logic [31:0] mask, exp);
      logic [31:0] x;
      av(1'b0, a, 32'h0, x);
      chk(nm, x & mask, exp);
   endtask : rdc
   task automatic i2c_wr(input logic [7:0] a, p, d, output logic [2:0] k);
      m.start();
      m.xfer(a, k[2]);
      m.xfer(p, k[1]);
      m.xfer(d, k[0]);
      m.stop();
   endtask : i2c_wr
   task automatic t_reset;
      rdc("ctrl reset", AV_CTRL, 32'hff, 32'h0e);
      rdc("osc flag reset", AV_STAT, 32'h2, 32'h2);
      chk("shared out idle", square_wave_or_irq_out_oe_n_o, 32'h1);
      rdc("unmapped", 5'h18, 32'hffffffff, 32'h0);
      rdc("clear reg", AV_IRQ_CLR, 32'hffffffff, 32'h0);
      wr(AV_STAT, 32'h0);
      wait_n(300);
      rdc("osc running", AV_STAT, 32'h2, 32'h0);
      $display("done reset");
   endtask : t_reset
   task automatic t_addr;
      logic [2:0] k;
      logic a;
      address_select_pin_i <= 1'b1;
      wait_n(4);
      wr(AV_IRQ_CLR, 32'hf);
      i2c_wr(8'ha0, 8'h07, 8'h08, k);
      chk("strap mismatch", k, 32'h0);
      i2c_wr(8'ha2, 8'h07, 8'h08, k);
      chk("strap match", k, 32'h7);
      rdc("ctrl by i2c", AV_CTRL, 32'hff, 32'h08);
      m.start();
      m.xfer(8'ha2, a);
      // pointer then wrap from 10h to 00h
      m.xfer(8'h10, a);
      for (int i = 0; i < 9; i++) m.xfer(i == 8 ? 8'h0e : 8'h55, a);
      m.stop();
      rdc("ctrl after wrap", AV_CTRL, 32'hff, 32'h0e);
      rdc("no stall", AV_IRQ_STAT, 32'h3, 32'h0);
      $display("done address");
   endtask : t_addr
   task automatic t_stall;
      logic [2:0] k;
      wr(AV_IRQ_CLR, 32'hf);
      m.start();
      m.send8(8'ha2);
      wait_n(1);
      chk("ack driven", sda_oe_n_o, 32'h0);
      wait_n(7000);
      rdc("stall seen", AV_IRQ_STAT, 32'h3, 32'h1);
      wait_n(2400);
      chk("sda released", sda_oe_n_o, 32'h1);
      rdc("stall reset", AV_IRQ_STAT, 32'h3, 32'h3);
      m.idle();
      i2c_wr(8'ha2, 8'h07, 8'h0e, k);
      chk("fresh start", k, 32'h7);
      $display("done stall");
   endtask : t_stall
   task automatic t_osc;
      wr(AV_CTRL, 32'h8e);
      wr(AV_IRQ_CLR, 32'hf);
      m.hold_low(400);
      rdc("osc off no reset", AV_IRQ_STAT, 32'h6, 32'h4);
      rdc("osc off flag", AV_STAT, 32'h2, 32'h2);
      wr(AV_CTRL, 32'h0e);
      wr(AV_STAT, 32'h0);
      osc_run <= 1'b1;
      wr(AV_CLKSRC, 32'h1);
      wr(AV_IRQ_CLR, 32'hf);
      wr(AV_STAT, 32'h0);
      m.hold_low(9400);
      rdc("ext stall", AV_IRQ_STAT, 32'h6, 32'h2);
      osc_run <= 1'b0;
      wait_n(300);
      rdc("ext stop", AV_STAT, 32'h2, 32'h2);
      wr(AV_CLKSRC, 32'h0);
      wr(AV_STAT, 32'h0);
      $display("done oscillator");
   endtask : t_osc
   task automatic t_out;
      int n;
      logic v;
      wr(AV_CTRL, 32'h09);
      wr(AV_IRQ_CLR, 32'hf);
      wr(AV_IRQ_EN, 32'h8);
      alarm_event_i <= 1'b1;
      @(posedge mclk_i);
      alarm_event_i <= 1'b0;
      wait_n(4);
      chk("alarm drive", square_wave_or_irq_out_oe_n_o, 32'h0);
      chk("irq raised", irq_o, 32'h1);
      wr(AV_IRQ_EN, 32'h0);
      wait_n(3);
      chk("irq masked", irq_o, 32'h0);
      wr(AV_STAT, 32'h2);
      wait_n(3);
      chk("alarm release", square_wave_or_irq_out_oe_n_o, 32'h1);
      wr(AV_IRQ_EN, 32'h8);
      wr(AV_IRQ_CLR, 32'h8);
      wait_n(3);
      chk("irq cleared", irq_o, 32'h0);
      wr(AV_CTRL, 32'h06);
      n = 0;
      v = square_wave_or_irq_out_oe_n_o;
      repeat (64) begin
         @(negedge mclk_i);
         if (square_wave_or_irq_out_oe_n_o !== v) n++;
         v = square_wave_or_irq_out_oe_n_o;
      end
      chk("square wave", 32'(n > 2), 32'h1);
      $display("done shared output");
   endtask : t_out
   initial begin
      rst_n_i = 1'b0;
      avs_address_i = 5'h0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      address_select_pin_i = 1'b0;
      alarm_event_i = 1'b0;
      osc_run = 1'b0;
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      wait_n(4);
      t_reset();
      t_addr();
      t_stall();
      t_osc();
      t_out();
      give_verdict();
   end
   initial begin
      #2400us;
      mismatches++;
      give_verdict();
   end
endmodule : test_i2c_slave_timeout_osc_monitor
